// ### core/adcrb_pkg.sv
package adcrb_pkg;
    // ----------------------------------------
    // register addresses and reset values
    // ----------------------------------------
    localparam logic [15:0] REG1_ADDR = 16'h0001;
    localparam logic [15:0] REG2_ADDR = 16'h0002;
    localparam logic [15:0] REG1_RST = 16'h001A;
    localparam logic [15:0] REG2_RST = 16'h009B;
    // ----------------------------------------
    // filter_and_readback_control fields
    // ----------------------------------------
    localparam int B_COEF_LOAD = 15;
    localparam int B_RD_OVR = 14;
    localparam int B_RD_GAIN = 13;
    localparam int B_RD_OFF = 12;
    localparam int B_RD_STAT = 11;
    localparam int B_SYNC = 9;
    localparam int B_TAP_HI = 8;
    localparam int B_TAP_LO = 5;
    localparam int B_FIR_USE = 4;
    localparam int B_F1_USE = 3;
    localparam int B_DEC_HI = 2;
    localparam int B_ONESHOT_LO = 9;
    localparam logic [2:0] DEC_MAX = 3'h5;
    // ----------------------------------------
    // clock_and_power_control fields
    // ----------------------------------------
    localparam int B_CLK_HALVE = 5;
    localparam int B_CHIP_SLEEP = 3;
    localparam int B_ECONOMY = 2;
    localparam int B_AMP_SLEEP = 0;
    // ----------------------------------------
    // coefficient download
    // ----------------------------------------
    localparam logic [5:0] MAX_COEF = 6'h30;
    localparam logic [5:0] COEF_STEP = 6'h06;
    localparam int STATUS_GOOD_BIT = 7;
    localparam int CLK_PERIOD_NS = 100;
    // half an internal clock period per unused slot, slowest case mclk/2
    localparam int FILL_NS = CLK_PERIOD_NS;
    localparam int FILL_CYC = (FILL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ----------------------------------------
    // write sequencer states
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_ADDR, ST_DATA, ST_COEF_HI, ST_COEF_LO, ST_CSUM, ST_FILL
    } adcrb_state_t;
endpackage

// ### core/adcrb_clk_div.sv
`timescale 1ns/100ps
`default_nettype none
module adcrb_clk_div (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // divide select, 1 gives full rate
    input wire logic clock_halve_select,
    // internal clock tick
    output logic internal_clock_tick
);
    logic phase_q, phase_d, tick_q, tick_d;

    // ----------------------------------------
    // divide by one or two
    // ----------------------------------------
    always_comb begin
        phase_d = ~phase_q;
        tick_d = clock_halve_select | phase_q;
    end

    // register the divider
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            phase_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            tick_q <= tick_d;
        end
    end

    assign internal_clock_tick = tick_q;
endmodule // adcrb_clk_div
`default_nettype wire

// ### core/adcrb_regs.sv
// Operation
// - address word then one 16-bit data word writes the addressed register
// - first control register at 0x0001, reset value 0x001A
// - bit 15 set: following writes are coefficients, then checksum
// - bits 14-11 select overrange, gain, offset or status for next read
// - bits 15-9 clear themselves after taking effect
// - bit 9 starts synchronisation, aligning filters across devices
// - bit 4 zero bypasses the FIR stage, one uses it
// - bit 3 zero bypasses the first filter, raw modulator data
// - bits 2-0 set second filter decimation, zero bypasses, up to 32x
// - second control register at 0x0002, reset value 0x009B
// - bit 5 zero halves master clock, one passes it through
// - bit 3 puts the whole converter to sleep
// - bit 2 selects economy mode with reduced noise performance
// - bit 0 sleeps the input amplifier only
// - unused slots filled with zeros, half internal clock each; code fills one slot per master clock, a full internal clock when bit 5 is one
// - byte checksum match sets status bit 7
`timescale 1ns/100ps
`default_nettype none
module adcrb_regs
    import adcrb_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // parallel bus
    input wire logic wr_strobe,
    input wire logic [15:0] wr_data,
    input wire logic rd_strobe,
    output logic [15:0] rd_data,
    // read-back sources
    input wire logic [15:0] conv_data,
    input wire logic [15:0] ovr_value,
    input wire logic [15:0] gain_value,
    input wire logic [15:0] offset_value,
    input wire logic [15:0] status_value,
    // filter controls
    output logic [3:0] fir_tap_count,
    output logic fir_stage_use,
    output logic first_stage_use,
    output logic [2:0] decimation_select,
    output logic sync_pulse,
    // clock and power
    output logic clock_halve_select,
    output logic chip_sleep,
    output logic economy_mode,
    output logic input_amp_sleep,
    output logic internal_clock_tick,
    // coefficient store
    output logic coef_wr,
    output logic [5:0] coef_index,
    output logic [26:0] coef_value,
    output logic coef_load_good
);
    adcrb_state_t st_q, st_d;
    logic [15:0] addr_q, addr_d, reg1_q, reg1_d, reg2_q, reg2_d;
    logic [15:0] csum_q, csum_d, hi_q, hi_d, rd_q, rd_d;
    logic [5:0] left_q, left_d, idx_q, idx_d;
    logic [3:0] sel_q, sel_d;
    logic good_q, good_d, cwr_q, cwr_d;
    logic [26:0] cval_q, cval_d;
    logic w1_hit, w2_hit;

    // byte sum of one word, 16 bits wide
    function automatic logic [15:0] byte_sum(input logic [15:0] w);
        byte_sum = {8'h00, w[15:8]} + {8'h00, w[7:0]};
    endfunction

    // coefficient count from tap field, zero means full length
    function automatic logic [5:0] coef_count(input logic [3:0] f);
        if (f == 4'h0)
            coef_count = MAX_COEF;
        else
            coef_count = 6'((({3'h0, f[3:1]}) + 6'h01) * COEF_STEP);
    endfunction

    assign w1_hit = wr_strobe && st_q == ST_DATA && addr_q == REG1_ADDR;
    assign w2_hit = wr_strobe && st_q == ST_DATA && addr_q == REG2_ADDR;

    // ----------------------------------------
    // write sequencer and control registers
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        addr_d = addr_q;
        reg1_d = {7'h00, reg1_q[B_ONESHOT_LO-1:0]}; // one-shots drop
        reg2_d = reg2_q;
        csum_d = csum_q;
        hi_d = hi_q;
        left_d = left_q;
        idx_d = cwr_q ? idx_q + 6'h01 : idx_q; // next slot after every store, in any state
        good_d = good_q;
        cwr_d = 1'b0;
        cval_d = cval_q;
        case (st_q)
            ST_ADDR: begin
                if (wr_strobe) begin
                    addr_d = wr_data; // address word first
                    st_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (wr_strobe) begin
                    st_d = ST_ADDR;
                    if (addr_q == REG1_ADDR) begin
                        reg1_d = wr_data;
                        if (wr_data[B_COEF_LOAD]) begin
                            st_d = ST_COEF_HI; // download entry
                            left_d = coef_count(wr_data[B_TAP_HI:B_TAP_LO]);
                            csum_d = 16'h0000;
                            idx_d = 6'h00;
                            good_d = 1'b0;
                        end
                    end else if (addr_q == REG2_ADDR) begin
                        reg2_d = wr_data;
                    end
                end
            end
            ST_COEF_HI: begin
                if (wr_strobe) begin
                    hi_d = wr_data; // sign and upper magnitude
                    csum_d = csum_q + byte_sum(wr_data);
                    st_d = ST_COEF_LO;
                end
            end
            ST_COEF_LO: begin
                if (wr_strobe) begin
                    csum_d = csum_q + byte_sum(wr_data);
                    cval_d = {hi_q[10:0], wr_data[15:0]}; // sign, full 26-bit magnitude
                    cwr_d = 1'b1;
                    left_d = left_q - 6'h01;
                    st_d = (left_q == 6'h01) ? ST_CSUM : ST_COEF_HI;
                end
            end
            ST_CSUM: begin
                if (wr_strobe) begin
                    good_d = (wr_data == csum_q); // checksum compare
                    left_d = MAX_COEF - idx_d;
                    st_d = (idx_d == MAX_COEF) ? ST_ADDR : ST_FILL;
                end
            end
            ST_FILL: begin
                // zero one unused slot per cycle, writes ignored
                cwr_d = 1'b1;
                cval_d = 27'h000_0000;
                left_d = left_q - 6'(FILL_CYC);
                if (left_q == 6'h01)
                    st_d = ST_ADDR;
            end
            default: st_d = ST_ADDR;
        endcase
    end

    // register the sequencer
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_q <= ST_ADDR;
            addr_q <= 16'h0000;
            reg1_q <= REG1_RST;
            reg2_q <= REG2_RST;
            csum_q <= 16'h0000;
            hi_q <= 16'h0000;
            left_q <= 6'h00;
            idx_q <= 6'h00;
            good_q <= 1'b0;
            cwr_q <= 1'b0;
            cval_q <= 27'h000_0000;
        end else begin
            st_q <= st_d;
            addr_q <= addr_d;
            reg1_q <= reg1_d;
            reg2_q <= reg2_d;
            csum_q <= csum_d;
            hi_q <= hi_d;
            left_q <= left_d;
            idx_q <= idx_d;
            good_q <= good_d;
            cwr_q <= cwr_d;
            cval_q <= cval_d;
        end
    end

    // ----------------------------------------
    // read-back selection and read data
    // ----------------------------------------
    always_comb begin
        sel_d = sel_q;
        rd_d = rd_q;
        if (rd_strobe) begin
            sel_d = 4'h0; // selection used by this read
            if (sel_q[3])
                rd_d = ovr_value;
            else if (sel_q[2])
                rd_d = gain_value;
            else if (sel_q[1])
                rd_d = offset_value;
            else if (sel_q[0])
                rd_d = {status_value[15:8], good_q, status_value[6:0]};
            else
                rd_d = conv_data;
        end
        if (w1_hit && wr_data[B_RD_OVR:B_RD_STAT] != 4'h0)
            sel_d = wr_data[B_RD_OVR:B_RD_STAT]; // new request wins
    end

    // register the read path
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            sel_q <= 4'h0;
            rd_q <= 16'h0000;
        end else begin
            sel_q <= sel_d;
            rd_q <= rd_d;
        end
    end

    // internal clock divider
    adcrb_clk_div u_div (
        .core_clk(core_clk),
        .rstn(rstn),
        .clock_halve_select(reg2_q[B_CLK_HALVE]),
        .internal_clock_tick(internal_clock_tick)
    );

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rd_data = rd_q;
    assign fir_tap_count = reg1_q[B_TAP_HI:B_TAP_LO];
    assign fir_stage_use = reg1_q[B_FIR_USE];
    assign first_stage_use = reg1_q[B_F1_USE];
    assign decimation_select = reg1_q[B_DEC_HI:0];
    assign sync_pulse = reg1_q[B_SYNC];
    assign clock_halve_select = reg2_q[B_CLK_HALVE];
    assign chip_sleep = reg2_q[B_CHIP_SLEEP];
    assign economy_mode = reg2_q[B_ECONOMY];
    assign input_amp_sleep = reg2_q[B_AMP_SLEEP];
    assign coef_wr = cwr_q;
    assign coef_index = idx_q;
    assign coef_value = cval_q;
    assign coef_load_good = good_q;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_addr_then_data;
        @(posedge core_clk) disable iff (!rstn)
        (wr_strobe && st_q == ST_ADDR) |=> st_q == ST_DATA ##0 addr_q == $past(wr_data);
    endproperty
    a_addr_then_data: assert property (p_addr_then_data) else $error("address word not taken");

    property p_reset_vals;
        @(posedge core_clk) $rose(rstn) |-> reg1_q == REG1_RST && reg2_q == REG2_RST;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");

    property p_load_entry;
        @(posedge core_clk) disable iff (!rstn)
        (w1_hit && wr_data[B_COEF_LOAD]) |=> st_q == ST_COEF_HI && !good_q;
    endproperty
    a_load_entry: assert property (p_load_entry) else $error("download not entered");

    property p_sync_oneshot;
        @(posedge core_clk) disable iff (!rstn)
        (w1_hit && wr_data[B_SYNC]) |=> sync_pulse ##1 !sync_pulse;
    endproperty
    a_sync_oneshot: assert property (p_sync_oneshot) else $error("sync not one-shot");

    property p_gain_read;
        @(posedge core_clk) disable iff (!rstn)
        (rd_strobe && sel_q[2] && !sel_q[3]) |=> rd_data == $past(gain_value);
    endproperty
    a_gain_read: assert property (p_gain_read) else $error("gain not read back");

    property p_reg1_fields;
        @(posedge core_clk) disable iff (!rstn)
        w1_hit |=> decimation_select == $past(wr_data[2:0]) && fir_stage_use == $past(wr_data[B_FIR_USE])
            && first_stage_use == $past(wr_data[B_F1_USE]);
    endproperty
    a_reg1_fields: assert property (p_reg1_fields) else $error("filter fields wrong");

    property p_reg2_fields;
        @(posedge core_clk) disable iff (!rstn)
        w2_hit |=> chip_sleep == $past(wr_data[B_CHIP_SLEEP]) && economy_mode == $past(wr_data[B_ECONOMY])
            && input_amp_sleep == $past(wr_data[B_AMP_SLEEP]) && clock_halve_select == $past(wr_data[5]);
    endproperty
    a_reg2_fields: assert property (p_reg2_fields) else $error("power fields wrong");

    property p_full_rate;
        @(posedge core_clk) disable iff (!rstn)
        clock_halve_select [*3] |-> internal_clock_tick;
    endproperty
    a_full_rate: assert property (p_full_rate) else $error("internal clock not full rate");

    property p_csum;
        @(posedge core_clk) disable iff (!rstn)
        (wr_strobe && st_q == ST_CSUM) |=> coef_load_good == ($past(wr_data) == $past(csum_q));
    endproperty
    a_csum: assert property (p_csum) else $error("checksum flag wrong");

    property p_fill_bound;
        @(posedge core_clk) disable iff (!rstn)
        $rose(st_q == ST_FILL) |=> coef_wr throughout (##[0:47] st_q == ST_ADDR);
    endproperty
    a_fill_bound: assert property (p_fill_bound) else $error("fill too long");

    c_download: cover property (@(posedge core_clk) disable iff (!rstn) st_q == ST_CSUM ##1 coef_load_good);
    c_fill: cover property (@(posedge core_clk) disable iff (!rstn) st_q == ST_FILL);
    c_status_read: cover property (@(posedge core_clk) disable iff (!rstn) rd_strobe && sel_q[0]);
endmodule // adcrb_regs
`default_nettype wire

// ### dv/adcrb_host.sv
`timescale 1ns/100ps
`default_nettype none
module adcrb_host
    import adcrb_pkg::*;
(
    // clock
    input wire logic core_clk,
    // parallel bus
    output logic wr_strobe,
    output logic [15:0] wr_data,
    output logic rd_strobe,
    input wire logic [15:0] rd_data
);
    // ----------------------------------------
    // bus cycles
    // ----------------------------------------
    // idle bus at time zero
    initial begin
        wr_strobe = 1'b0;
        wr_data = 16'h5a5a;
        rd_strobe = 1'b0;
    end
    // one word, taken at the edge after set-up
    task automatic word(input logic [15:0] w);
        @(posedge core_clk);
        #1;
        wr_strobe = 1'b1;
        wr_data = w;
        @(posedge core_clk);
        #1;
        wr_strobe = 1'b0;
        wr_data = ~w; // released bus no longer shows the word
    endtask
    // address word then data word, fixed bits forced legal
    task automatic reg_wr(input logic [15:0] addr, input logic [15:0] d);
        logic [15:0] v;
        v = d;
        if (addr == REG1_ADDR) begin
            v[10] = 1'b0;
        end
        if (addr == REG2_ADDR) begin
            v = (v & 16'h002d) | 16'h0002;
        end
        word(addr);
        word(v);
    endtask
    // read strobe, result one cycle later
    task automatic rd(output logic [15:0] d);
        @(posedge core_clk);
        #1;
        rd_strobe = 1'b1;
        @(posedge core_clk);
        #1;
        rd_strobe = 1'b0;
        d = rd_data;
    endtask
endmodule // adcrb_host
`default_nettype wire

// ### dv/adc_control_register_bank_test.sv
`timescale 1ns/100ps
`default_nettype none
module adc_control_register_bank_test;
    import adcrb_pkg::*;
    // ----------------------------------------
    // signals and model state
    // ----------------------------------------
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic wr_strobe, rd_strobe, fir_stage_use, first_stage_use, sync_pulse, clock_halve_select;
    logic chip_sleep, economy_mode, input_amp_sleep, internal_clock_tick, coef_wr, coef_load_good;
    logic [15:0] wr_data, rd_data, conv_data, ovr_value, gain_value, offset_value, status_value;
    logic [3:0] fir_tap_count;
    logic [2:0] decimation_select;
    logic [5:0] coef_index;
    logic [26:0] coef_value;
    logic [15:0] m1, m2;
    logic good_m;
    logic [32:0] cq[$];
    int err_count = 0;
    int n_tests = 0;
    // 10 MHz master clock
    always #50 core_clk = ~core_clk;
    // collect every coefficient store
    always @(posedge core_clk) begin
        if (coef_wr === 1'b1) cq.push_back({coef_index, coef_value});
    end
    adcrb_host host (.core_clk(core_clk), .wr_strobe(wr_strobe), .wr_data(wr_data),
        .rd_strobe(rd_strobe), .rd_data(rd_data));
    adcrb_regs uut (.core_clk(core_clk), .rstn(rstn), .wr_strobe(wr_strobe), .wr_data(wr_data),
        .rd_strobe(rd_strobe), .rd_data(rd_data), .conv_data(conv_data), .ovr_value(ovr_value),
        .gain_value(gain_value), .offset_value(offset_value), .status_value(status_value),
        .fir_tap_count(fir_tap_count), .fir_stage_use(fir_stage_use), .first_stage_use(first_stage_use),
        .decimation_select(decimation_select), .sync_pulse(sync_pulse),
        .clock_halve_select(clock_halve_select), .chip_sleep(chip_sleep), .economy_mode(economy_mode),
        .input_amp_sleep(input_amp_sleep), .internal_clock_tick(internal_clock_tick), .coef_wr(coef_wr),
        .coef_index(coef_index), .coef_value(coef_value), .coef_load_good(coef_load_good));
    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // all register field outputs except sync_pulse against the model
    task automatic check_outs();
        chk("fir_tap_count", 32'(m1[8:5]), 32'(fir_tap_count));
        chk("fir_stage_use", 32'(m1[4]), 32'(fir_stage_use));
        chk("first_stage_use", 32'(m1[3]), 32'(first_stage_use));
        chk("decimation_select", 32'(m1[2:0]), 32'(decimation_select));
        chk("clock_halve_select", 32'(m2[5]), 32'(clock_halve_select));
        chk("chip_sleep", 32'(m2[3]), 32'(chip_sleep));
        chk("economy_mode", 32'(m2[2]), 32'(economy_mode));
        chk("input_amp_sleep", 32'(m2[0]), 32'(input_amp_sleep));
    endtask
    // each read-back select once, each followed by a plain conversion read
    task automatic read_selects();
        logic [15:0] d, e;
        for (int b = B_RD_STAT; b <= B_RD_OVR; b++) begin
            host.reg_wr(REG1_ADDR, m1 | (16'h0001 << b));
            host.rd(d);
            e = (b == B_RD_OVR) ? ovr_value : (b == B_RD_GAIN) ? gain_value :
                (b == B_RD_OFF) ? offset_value : {status_value[15:8], good_m, status_value[6:0]};
            chk("rd_data select", 32'(e), 32'(d));
            host.rd(d);
            chk("rd_data plain", 32'(conv_data), 32'(d));
        end
    endtask
    // coefficient download with hi and lo words, then checksum and fill
    task automatic download(input logic [3:0] f, input logic bad);
        logic [15:0] hi, lo, sum, v;
        logic [26:0] c;
        logic [32:0] eq[$];
        int n;
        n = ((f >> 1) + 1) * 6;
        sum = 16'h0000;
        cq.delete();
        v = 16'h8019 | (16'(f) << 5);
        host.reg_wr(REG1_ADDR, v);
        m1 = v & 16'h01ff;
        for (int k = 0; k < n; k++) begin
            c = 27'($urandom);
            hi = {5'h00, c[26:16]};
            lo = c[15:0];
            sum = sum + hi[15:8] + hi[7:0] + lo[15:8] + lo[7:0];
            host.word(hi);
            host.word(lo);
            eq.push_back({6'(k), c});
        end
        host.word(bad ? ~sum : sum);
        repeat (60) @(posedge core_clk);
        #1;
        for (int k = n; k < 48; k++) eq.push_back({6'(k), 27'h000_0000});
        chk("coef_count", 32'(eq.size()), 32'(cq.size()));
        for (int k = 0; k < eq.size() && k < cq.size(); k++) begin
            chk("coef_index", 32'(eq[k][32:27]), 32'(cq[k][32:27]));
            chk("coef_value", 32'(eq[k][26:0]), 32'(cq[k][26:0]));
        end
        good_m = !bad;
        chk("coef_load_good", 32'(good_m), 32'(coef_load_good));
        check_outs();
    endtask
    // verdict and end of run
    task automatic final_report();
        if (err_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------
    // watchdog and main sequence
    // ----------------------------------------
    initial begin
        #(100 * 20000);
        err_count++;
        final_report();
    end
    // reset, field writes, selects, clock and power, downloads
    initial begin
        logic [15:0] v;
        int n;
        void'($urandom(32'h6ac0_75dc));
        conv_data = 16'($urandom);
        ovr_value = 16'($urandom);
        gain_value = 16'($urandom);
        offset_value = 16'($urandom);
        status_value = 16'($urandom);
        m1 = REG1_RST;
        m2 = REG2_RST;
        good_m = 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        rstn = 1'b1;
        check_outs();
        chk("rd_data reset", 32'h0000_0000, 32'(rd_data));
        for (int i = 0; i < 8; i++) begin
            v = (16'($urandom) & 16'h01f8) | 16'(i % 6) | (16'(i[0]) << B_SYNC);
            host.reg_wr(REG1_ADDR, v);
            m1 = v & 16'h01ff;
            check_outs();
            chk("sync_pulse", 32'(v[B_SYNC]), 32'(sync_pulse));
            @(posedge core_clk);
            #1;
            chk("sync_pulse clear", 32'h0000_0000, 32'(sync_pulse));
        end
        read_selects();
        for (int i = 0; i < 8; i++) begin
            v = (16'($urandom) & 16'h000d) | (16'(i[0]) << B_CLK_HALVE);
            host.reg_wr(REG2_ADDR, v);
            m2 = (v & 16'h002d) | 16'h0002;
            check_outs();
            n = 0;
            repeat (8) begin
                @(posedge core_clk);
                #1;
                n += (internal_clock_tick === 1'b1) ? 1 : 0;
            end
            chk("tick_count", m2[5] ? 32'd8 : 32'd4, 32'(n));
        end
        host.reg_wr(16'h0003, 16'hffff);
        host.reg_wr(16'h0000, 16'h0000);
        check_outs();
        download(4'h3, 1'b0);
        read_selects();
        download(4'hf, 1'b1);
        read_selects();
        final_report();
    end
endmodule // adc_control_register_bank_test
`default_nettype wire
